// >>> hdl/fapw_supervisor.sv
// Purpose: Auto powerdown and wake supervisor for the floppy controller function.
// Assumes: Host strobes are one-cycle pulses synchronous to ref_clk, already qualified
//          by chip select and DMA acknowledge decoding outside this block.
// Notes:   The core keeps its state while asleep; only its clock gate is dropped.
// Notes on behaviour
// - Hardware or software reset ending powerdown runs the full core reset sequence.
// - Register wake resumes with all internal state kept intact.
// - Writing a motor enable bit wakes; reading drive output control does not.
// - Main status read wakes the controller.
// - Any data port read or write wakes the controller.
// - After waking the idle timer restarts at 10 ms; sleep again needs all conditions.
// - Status, drive control, rate select, input and config registers wake only on motor enable or software reset writes.
// - Non-waking reads while asleep return the true current status.
// - Non-waking writes while asleep are stored and apply once awake.
// - Plain control writes stay asleep; motor enable or software reset writes wake.
// - After a served non-waking access the block returns to low power.
// - Host side stays monitored while asleep; interrupt and DMA request held low.
// - Motor, select, write data, write gate tristate; step and rate pins stay driven.
// - Local logic pins keep function; drive inputs remain inputs.
// - Sleep needs enable, motors off, main status idle, no interrupt, timers expired.
// - Auto powerdown allowed only with enable bit 7 set; clearing cancels it.
// - Main status reads or data port accesses restart the idle timer.
// A shorter idle period may be set for a quick derived test; the default is the full span.
module fapw_supervisor #(
    parameter int IDLE_PERIOD = fapw_pkg::IDLE_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       host_rd,
    input  wire logic       host_wr,
    input  wire logic [2:0] host_addr,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    input  wire logic [7:0] auto_power_enable_reg,
    input  wire logic [7:0] core_main_status,
    input  wire logic [7:0] core_data_rd,
    input  wire logic [7:0] core_status_a,
    input  wire logic [7:0] core_status_b,
    input  wire logic [7:0] core_drive_input,
    input  wire logic       core_irq,
    input  wire logic       core_dma_req,
    input  wire logic       core_head_unload_done,
    input  wire logic [3:0] core_drive_select,
    input  wire logic       core_write_stream,
    input  wire logic       core_write_gate,
    input  wire logic       core_step_dir,
    input  wire logic       core_step,
    input  wire logic       core_head_side,
    input  wire logic       core_density,
    input  wire logic [1:0] core_rate,
    output logic            core_clk_enable,
    output logic            core_reset,
    output logic            core_data_rd_stb,
    output logic            core_data_wr_stb,
    output logic      [7:0] core_data_wdata,
    output logic      [7:0] drive_output_control,
    output logic      [7:0] data_rate_select,
    output logic      [7:0] rate_config,
    output logic            asleep,
    output logic            floppy_irq_out,
    output logic            floppy_dma_request,
    output logic      [3:0] motor_on_outputs,
    output logic      [3:0] motor_on_oe,
    output logic      [3:0] drive_select_outputs,
    output logic      [3:0] drive_select_oe,
    output logic            write_stream_out,
    output logic            write_stream_oe,
    output logic            write_gate_out,
    output logic            write_gate_oe,
    output logic            step_dir_out,
    output logic            step_out,
    output logic            head_side_select,
    output logic            density_select_out,
    output logic      [1:0] rate_select_out
);
    import fapw_pkg::*;

    fapw_state_e state;
    fapw_state_e next_state;
    logic        idle_expired;

    // Address decode of host accesses.
    wire rd_main   = host_rd && (host_addr == OFS_MAIN_STATUS);
    wire acc_data  = (host_rd || host_wr) && (host_addr == OFS_DATA_PORT);
    wire wr_dor    = host_wr && (host_addr == OFS_DRIVE_OUT);
    wire wr_dsr    = host_wr && (host_addr == OFS_MAIN_STATUS);
    wire wr_ccr    = host_wr && (host_addr == OFS_DRIVE_INPUT);
    wire any_acc   = host_rd || host_wr;

    // Software reset: drive control reset bit low, or rate select reset bit high.
    wire dor_sw_reset = wr_dor && !host_wdata[DOR_RESET_N_BIT];
    wire dsr_sw_reset = wr_dsr && host_wdata[DSR_SW_RESET_BIT];
    wire sw_reset     = dor_sw_reset || dsr_sw_reset;
    wire motor_wake   = wr_dor && (host_wdata[DOR_MOTOR_LSB+3:DOR_MOTOR_LSB] != MOTOR_NONE);
    // Reads of drive output control, status and input registers do not appear here.
    wire reg_wake     = rd_main || acc_data || motor_wake;
    wire wake_evt     = reg_wake || sw_reset;
    wire timer_kick   = rd_main || acc_data;

    wire ap_enabled   = auto_power_enable_reg[AP_ENABLE_BIT];
    wire motors_off   = (drive_output_control[DOR_MOTOR_LSB+3:DOR_MOTOR_LSB] == MOTOR_NONE);
    wire core_idle    = (core_main_status == MSR_IDLE) && !core_irq;
    wire sleep_ok     = ap_enabled && motors_off && core_idle
                        && core_head_unload_done && idle_expired;

    // The timer re-arms from full period on every awake entry and kick.
    fapw_idle_timer #(
        .PERIOD (IDLE_PERIOD[TIMER_W-1:0])
    ) u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .armed   (ap_enabled && (state == FAPW_AWAKE)),
        .restart (timer_kick || wake_evt),
        .expired (idle_expired)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            FAPW_AWAKE: begin
                if (sleep_ok && !any_acc) begin
                    next_state = FAPW_ASLEEP;
                end
            end
            FAPW_ASLEEP: begin
                if (wake_evt || !ap_enabled) begin
                    next_state = FAPW_AWAKE;
                end else if (any_acc) begin
                    next_state = FAPW_SERVE;
                end
            end
            FAPW_SERVE: begin
                // Served silently for one cycle, then back to low power.
                if (wake_evt || !ap_enabled) begin
                    next_state = FAPW_AWAKE;
                end else if (!any_acc) begin
                    next_state = FAPW_ASLEEP;
                end
            end
            default: next_state = FAPW_AWAKE;
        endcase
    end

    wire next_sleep = (next_state != FAPW_AWAKE);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= FAPW_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // Control registers accept writes in every state so asleep writes are kept.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drive_output_control <= DOR_RESET_VALUE;
            data_rate_select     <= DSR_RESET_VALUE;
            rate_config          <= CCR_RESET_VALUE;
        end else begin
            if (wr_dor) drive_output_control <= host_wdata;
            if (wr_dsr) data_rate_select     <= host_wdata;
            if (wr_ccr) rate_config          <= host_wdata;
        end
    end

    // Reads come from live core status, not a snapshot, so asleep reads are true.
    logic [7:0] rd_mux;
    always_comb begin
        unique case (host_addr)
            OFS_STATUS_A:    rd_mux = core_status_a;
            OFS_STATUS_B:    rd_mux = core_status_b;
            OFS_DRIVE_OUT:   rd_mux = drive_output_control;
            OFS_MAIN_STATUS: rd_mux = core_main_status;
            OFS_DATA_PORT:   rd_mux = core_data_rd;
            OFS_DRIVE_INPUT: rd_mux = core_drive_input;
            default:         rd_mux = 8'h00;
        endcase
    end

    // Next values of the host-side and core-side controls.
    wire next_clk_en   = !next_sleep || sw_reset;
    wire next_irq      = core_irq && !next_sleep;
    wire next_dma_req  = core_dma_req && !next_sleep;
    wire data_rd_acc   = acc_data && host_rd;
    wire data_wr_acc   = acc_data && host_wr;
    wire next_wstream  = core_write_stream && !next_sleep;
    wire next_wgate    = core_write_gate && !next_sleep;

    // Host side keeps decoding while asleep, so reads are captured in every state.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            host_rdata <= rd_mux;
        end
    end

    // The core is held in reset for one cycle after a software reset write.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_clk_enable <= 1'b1;
            core_reset      <= 1'b1;
        end else begin
            core_clk_enable <= next_clk_en;
            core_reset      <= sw_reset;
        end
    end

    // Data port strobes to the core; a waking access reaches the core intact.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_data_rd_stb <= 1'b0;
            core_data_wr_stb <= 1'b0;
        end else begin
            core_data_rd_stb <= data_rd_acc;
            core_data_wr_stb <= data_wr_acc;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_data_wdata <= 8'h00;
        end else if (data_wr_acc) begin
            core_data_wdata <= host_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            asleep <= 1'b0;
        end else begin
            asleep <= next_sleep;
        end
    end

    // Requests are gated with the next state so they never glitch high on entry.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            floppy_irq_out     <= 1'b0;
            floppy_dma_request <= 1'b0;
        end else begin
            floppy_irq_out     <= next_irq;
            floppy_dma_request <= next_dma_req;
        end
    end

    // Per-drive pins. Motor values come from the stored drive control register, select values from core_drive_select.
    genvar drv;
    generate
        for (drv = 0; drv < $bits(motor_on_outputs); drv++) begin : g_drive
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    motor_on_outputs[drv]     <= 1'b0;
                    motor_on_oe[drv]          <= 1'b1;
                    drive_select_outputs[drv] <= 1'b0;
                    drive_select_oe[drv]      <= 1'b1;
                end else begin
                    motor_on_outputs[drv]     <= drive_output_control[DOR_MOTOR_LSB+drv];
                    motor_on_oe[drv]          <= !next_sleep;
                    drive_select_outputs[drv] <= core_drive_select[drv];
                    drive_select_oe[drv]      <= !next_sleep;
                end
            end
        end
    endgenerate

    // Write path pins float while asleep and come back low, not mid-pulse.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            write_stream_out <= 1'b0;
            write_stream_oe  <= 1'b1;
            write_gate_out   <= 1'b0;
            write_gate_oe    <= 1'b1;
        end else begin
            write_stream_out <= next_wstream;
            write_stream_oe  <= !next_sleep;
            write_gate_out   <= next_wgate;
            write_gate_oe    <= !next_sleep;
        end
    end

    // These stay driven during powerdown; drive inputs need no change.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            step_dir_out       <= 1'b0;
            step_out           <= 1'b0;
            head_side_select   <= 1'b0;
            density_select_out <= 1'b0;
            rate_select_out    <= 2'h0;
        end else begin
            step_dir_out       <= core_step_dir;
            step_out           <= core_step;
            head_side_select   <= core_head_side;
            density_select_out <= core_density;
            rate_select_out    <= core_rate;
        end
    end
endmodule

// >>> hdl/fapw_pkg.sv
// Purpose: Shared constants for the floppy controller auto powerdown supervisor.
// Assumes: 50 MHz ref_clk, register offsets relative to the controller base.
// Notes:   Field positions follow the drive output control and rate select layouts.
package fapw_pkg;
    localparam logic [2:0] OFS_STATUS_A     = 3'h0;
    localparam logic [2:0] OFS_STATUS_B     = 3'h1;
    localparam logic [2:0] OFS_DRIVE_OUT    = 3'h2;
    localparam logic [2:0] OFS_MAIN_STATUS  = 3'h4;
    localparam logic [2:0] OFS_DATA_PORT    = 3'h5;
    localparam logic [2:0] OFS_DRIVE_INPUT  = 3'h7;

    localparam int DOR_RESET_N_BIT = 2;
    localparam int DOR_MOTOR_LSB   = 4;
    localparam int DSR_SW_RESET_BIT = 7;
    localparam int AP_ENABLE_BIT   = 7;

    localparam logic [7:0] DOR_RESET_VALUE  = 8'h00;
    localparam logic [7:0] DSR_RESET_VALUE  = 8'h02;
    localparam logic [7:0] CCR_RESET_VALUE  = 8'h02;
    localparam logic [7:0] MSR_IDLE         = 8'h80;
    localparam logic [3:0] MOTOR_NONE       = 4'h0;

    localparam int CLK_HZ          = 50_000_000;
    localparam int IDLE_TIME_MS    = 10;
    localparam int IDLE_CYCLES     = (CLK_HZ / 1000) * IDLE_TIME_MS;
    localparam int TIMER_W         = 20;

    typedef enum logic [1:0] {
        FAPW_AWAKE  = 2'b00,
        FAPW_ASLEEP = 2'b01,
        FAPW_SERVE  = 2'b11
    } fapw_state_e;
endpackage

// >>> hdl/fapw_idle_timer.sv
// Purpose: Down counter that reports when the controller has been idle long enough.
// Assumes: restart has priority over counting; armed low holds the count at PERIOD.
// Notes:   Expired stays high until the next restart or disarm.
module fapw_idle_timer #(
    parameter logic [19:0] PERIOD = 20'h7a120
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic armed,
    input  wire logic restart,
    output logic      expired
);
    import fapw_pkg::*;

    logic [TIMER_W-1:0] count;
    logic               running;
    wire                at_end = (count == '0);

    always_ff @(posedge ref_clk) begin
        if (reset || !armed) begin
            count   <= PERIOD;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (restart || !running) begin
            count   <= PERIOD;
            running <= 1'b1;
            expired <= 1'b0;
        end else if (at_end) begin
            expired <= 1'b1;
        end else begin
            count <= count - 1'b1;
        end
    end
endmodule

// >>> test/fapw_core_model.sv
// Purpose: Behavioural floppy core on the far side of the supervisor.
// Assumes: The core idles at main status 80h with no interrupt or request.
// Notes:   The data port echoes the last byte taken, so lost state shows at once.
module fapw_core_model
    import fapw_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       core_reset,
    input  wire logic       core_data_wr_stb,
    input  wire logic [7:0] core_data_wdata,
    output logic      [7:0] core_main_status,
    output logic      [7:0] core_data_rd,
    output logic            core_irq,
    output logic            core_dma_req,
    output logic            core_head_unload_done
);
    timeunit 1ns;
    timeprecision 1ps;
    assign core_main_status = MSR_IDLE;
    assign core_irq = 1'b0;
    assign core_dma_req = 1'b0;
    assign core_head_unload_done = 1'b1;
    always_ff @(posedge ref_clk) begin
        if (core_reset)
            core_data_rd <= 8'h00;
        else if (core_data_wr_stb)
            core_data_rd <= core_data_wdata;
    end
endmodule

// >>> test/fapw_checker_sva.sv
// Purpose: Concurrent checks on the supervisor ports.
// Assumes: Host strobes are one-cycle pulses sampled on ref_clk.
// Notes:   The timer span is judged by the bench, as a counter here would cost too much.
module fapw_checker
    import fapw_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       host_rd,
    input wire logic       host_wr,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] auto_power_enable_reg,
    input wire logic [7:0] core_main_status,
    input wire logic       core_irq,
    input wire logic       core_head_unload_done,
    input wire logic       core_clk_enable,
    input wire logic       core_reset,
    input wire logic       asleep,
    input wire logic       floppy_irq_out,
    input wire logic       floppy_dma_request,
    input wire logic [3:0] motor_on_outputs,
    input wire logic [3:0] motor_on_oe,
    input wire logic [3:0] drive_select_oe,
    input wire logic       write_stream_oe,
    input wire logic       write_gate_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic ap_on = auto_power_enable_reg[AP_ENABLE_BIT];
    wire logic idle_ok = motor_on_outputs == MOTOR_NONE && core_main_status == MSR_IDLE
                         && !core_irq && core_head_unload_done && ap_on;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence s_status_rd;
        asleep && host_rd && host_addr == OFS_MAIN_STATUS;
    endsequence
    sequence s_data_acc;
        asleep && (host_rd || host_wr) && host_addr == OFS_DATA_PORT;
    endsequence
    sequence s_awake;
        !asleep && core_clk_enable && motor_on_oe == 4'hf && drive_select_oe == 4'hf;
    endsequence
    wake_status_a: assert property (s_status_rd |=> s_awake)
        else $error("status read left the block asleep");
    wake_data_a: assert property (s_data_acc |=> s_awake)
        else $error("data access left the block asleep");
    dor_read_quiet_a: assert property (
        asleep && host_rd && host_addr == OFS_DRIVE_OUT && ap_on |=> asleep)
        else $error("drive control read woke the block");
    motor_wake_a: assert property (
        host_wr && host_addr == OFS_DRIVE_OUT && host_wdata[7:4] != MOTOR_NONE |=> !asleep)
        else $error("motor write did not wake the block");
    soft_reset_a: assert property (
        host_wr && host_addr == OFS_MAIN_STATUS && host_wdata[DSR_SW_RESET_BIT]
        |-> ##[1:2] core_reset) else $error("soft reset gave no core reset");
    host_lines_low_a: assert property (asleep |-> !floppy_irq_out && !floppy_dma_request)
        else $error("request line high while asleep");
    drive_float_a: assert property (asleep |-> motor_on_oe == 4'h0 && drive_select_oe == 4'h0
        && !write_stream_oe && !write_gate_oe) else $error("drive pin driven while asleep");
    enable_off_a: assert property (!ap_on |=> !asleep)
        else $error("asleep with auto powerdown disabled");
    entry_cond_a: assert property ($rose(asleep) |-> $past(idle_ok))
        else $error("sleep entered without all conditions");
endmodule

bind fapw_supervisor fapw_checker u_fapw_checker (.*);

// >>> test/test_fdc_auto_powerdown_wake.sv
// Purpose: Self-checking bench for the auto powerdown supervisor.
// Assumes: The idle period is shortened to SIM_IDLE cycles to keep the run brief.
// Notes:   Two sleep entries are run; other wake causes also rest on the checker.
module test_fdc_auto_powerdown_wake
    import fapw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0, reset = 1'b1, host_rd = 1'b0, host_wr = 1'b0;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] host_wdata = 8'h00, auto_power_enable_reg = 8'h80;
    logic [7:0] core_status_a = 8'ha5, core_status_b = 8'h5a, core_drive_input = 8'h80;
    logic [3:0] core_drive_select = 4'h1;
    logic [1:0] core_rate = 2'h2;
    logic       core_step = 1'b1, core_step_dir = 1'b1, core_head_side = 1'b0;
    logic       core_density = 1'b1, core_write_stream = 1'b0, core_write_gate = 1'b0;
    logic [7:0] core_main_status, core_data_rd, host_rdata, core_data_wdata;
    logic [7:0] drive_output_control, data_rate_select, rate_config;
    logic [3:0] motor_on_outputs, motor_on_oe, drive_select_oe;
    logic       core_irq, core_dma_req, core_head_unload_done, core_clk_enable, core_reset;
    logic       core_data_rd_stb, core_data_wr_stb, asleep, step_out, write_gate_oe;
    logic       floppy_irq_out, floppy_dma_request, write_stream_oe;
    int         err_count = 0;
    int         n_checks = 0;
    localparam int SIM_IDLE = 2000;

    fapw_supervisor #(.IDLE_PERIOD(SIM_IDLE)) u_fapw_supervisor (.*,
        .drive_select_outputs(), .write_stream_out(),
        .write_gate_out(), .step_dir_out(), .head_side_select(), .density_select_out(),
        .rate_select_out());
    fapw_core_model u_fapw_core_model (.*);

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle strobe launched at a falling edge; results are settled when it returns.
    task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        host_wr = wr;
        host_rd = !wr;
        host_addr = a;
        host_wdata = d;
        @(negedge ref_clk);
        host_rd = 1'b0;
        host_wr = 1'b0;
    endtask

    task automatic t_sleep();
        int n = 0;
        while (asleep !== 1'b1 && n < 4 * SIM_IDLE) begin
            @(negedge ref_clk);
            n++;
        end
        chk("idle span", 8'h01, {7'h0, n >= SIM_IDLE - 2});
        chk("asleep", 8'h01, {7'h0, asleep});
        chk("oe", 8'h00, {motor_on_oe, drive_select_oe});
        chk("gate oe, step", 8'h01, {6'h0, write_gate_oe, step_out});
    endtask

    task automatic t_quiet();
        logic [2:0] ra[4] = '{OFS_STATUS_A, OFS_STATUS_B, OFS_DRIVE_INPUT, OFS_DRIVE_OUT};
        logic [7:0] re[4] = '{8'h3c, 8'h5a, 8'h80, 8'h00};
        core_status_a = 8'h3c;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, ra[i], 8'h00);
            chk("read", re[i], host_rdata);
            chk("asleep", 8'h01, {7'h0, asleep});
        end
        acc(1'b1, OFS_DRIVE_OUT, 8'h0c);
        acc(1'b1, OFS_MAIN_STATUS, 8'h01);
        acc(1'b1, OFS_DRIVE_INPUT, 8'h01);
        chk("asleep", 8'h01, {7'h0, asleep});
        chk("dor", 8'h0c, drive_output_control);
        chk("dsr", 8'h01, data_rate_select);
        chk("ccr", 8'h01, rate_config);
    endtask

    task automatic t_wake_status();
        acc(1'b0, OFS_MAIN_STATUS, 8'h00);
        chk("status", MSR_IDLE, host_rdata);
        chk("awake", 8'h01, {6'h0, asleep, core_clk_enable});
        chk("oe", 8'hff, {motor_on_oe, drive_select_oe});
        chk("dor kept", 8'h0c, drive_output_control);
    endtask

    task automatic t_wake_data();
        acc(1'b1, OFS_DATA_PORT, 8'h96);
        chk("asleep", 8'h00, {7'h0, asleep});
        acc(1'b0, OFS_DATA_PORT, 8'h00);
        chk("data back", 8'h96, host_rdata);
        acc(1'b1, OFS_DRIVE_OUT, 8'h1c);
        @(negedge ref_clk);
        chk("motors", 8'h01, {4'h0, motor_on_outputs});
        acc(1'b1, OFS_MAIN_STATUS, 8'h80);
        chk("core reset", 8'h01, {7'h0, core_reset});
        acc(1'b0, OFS_DATA_PORT, 8'h00);
        chk("data cleared", 8'h00, host_rdata);
        auto_power_enable_reg = 8'h00;
        repeat (4) @(negedge ref_clk);
        chk("asleep", 8'h00, {7'h0, asleep});
    endtask

    initial begin
        repeat (20_000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        chk("dor", DOR_RESET_VALUE, drive_output_control);
        chk("dsr", DSR_RESET_VALUE, data_rate_select);
        chk("ccr", CCR_RESET_VALUE, rate_config);
        t_sleep();
        t_quiet();
        t_wake_status();
        t_sleep();
        t_wake_data();
        close_out();
    end
endmodule
